// file: logic/fsa_pkg.sv
// Constants shared by the flow sample averager and its helpers
// ==========================================================================
// Notes on behaviour
// - Ready for host access within 25 ms of power-up
// - Ready again within 25 ms after soft reset
// - Flow value and high flag refresh at 2000 Hz
// - Temperature and air flag refresh near 83 Hz
// - Start command begins back-to-back 0.5 ms samples
// - Result is mean of samples since last readout
// - After 100 ms, smoothing with factor 0.0125 seeded by mean
// - Each sample updates smoothed state; readout returns it
// - Flag bit 5 shows smoothing is active
// - Temperature sampled every 12 ms, never averaged
// - High flow sets flag bit 1 until flags read
// - Air in line sets flag bit 0 until flags read
// - Failure flag reports any event since last readout
// - Active-low alert low on new data, released by flow read
// - Start commands pick water or alcohol calibration
// - Read words are 16 bits plus an 8-bit checksum
// - Heater off after reset; first result 12.5 ms after start (12 ms warm-up, then one 0.5 ms sample)
// ==========================================================================
`default_nettype none
package fsa_pkg;
   // ========================================================================
   // Clock and timing
   localparam int unsigned CLK_HZ           = 250_000_000;
   localparam int unsigned FLOW_RATE_HZ     = 2000;
   localparam int unsigned FLOW_PERIOD_CYC  = CLK_HZ / FLOW_RATE_HZ;
   localparam int unsigned TEMP_PERIOD_US   = 12000;
   localparam int unsigned TEMP_PERIOD_CYC  = CLK_HZ / 1_000_000 * TEMP_PERIOD_US;
   localparam int unsigned READY_TIME_US    = 25000;
   localparam int unsigned READY_CYC        = CLK_HZ / 1_000_000 * READY_TIME_US;
   localparam int unsigned FIRST_RESULT_US  = 12000;
   localparam int unsigned FIRST_RESULT_CYC = CLK_HZ / 1_000_000 * FIRST_RESULT_US;
   localparam int unsigned SMOOTH_WINDOW_MS = 100;
   localparam int unsigned SMOOTH_SAMPLES   = SMOOTH_WINDOW_MS * FLOW_RATE_HZ / 1000;
   localparam int unsigned ALPHA_DIV        = 80;   // Smoothing factor 0.0125 = 1/80
   localparam int unsigned EMA_FRAC         = 8;
   // ========================================================================
   // Widths
   localparam int unsigned WORD_W = 16;
   localparam int unsigned CRC_W  = 8;
   localparam int unsigned ADDR_W = 3;
   localparam int unsigned CNT_W  = 32;
   // ========================================================================
   // Register offsets
   localparam logic [ADDR_W-1:0] REG_CMD    = 3'h0;
   localparam logic [ADDR_W-1:0] REG_FLOW   = 3'h1;
   localparam logic [ADDR_W-1:0] REG_TEMP   = 3'h2;
   localparam logic [ADDR_W-1:0] REG_FLAGS  = 3'h3;
   localparam logic [ADDR_W-1:0] REG_STATUS = 3'h4;
   // ========================================================================
   // Commands
   localparam logic [WORD_W-1:0] CMD_START_WATER   = 16'h3608;
   localparam logic [WORD_W-1:0] CMD_START_ALCOHOL = 16'h3615;
   localparam logic [WORD_W-1:0] CMD_STOP          = 16'h3FF9;
   localparam logic [WORD_W-1:0] CMD_SOFT_RESET    = 16'h0006;
   // ========================================================================
   // Flag word bits
   localparam int unsigned FLAG_AIR_BIT    = 0;
   localparam int unsigned FLAG_HIGH_BIT   = 1;
   localparam int unsigned FLAG_SMOOTH_BIT = 5;
   // Status word bits
   localparam int unsigned STAT_READY_BIT   = 0;
   localparam int unsigned STAT_MEAS_BIT    = 1;
   localparam int unsigned STAT_ALCOHOL_BIT = 2;
   localparam int unsigned STAT_HEATER_BIT  = 3;
   // ========================================================================
   // Checksum
   localparam logic [CRC_W-1:0] CRC_POLY = 8'h31;
   localparam logic [CRC_W-1:0] CRC_INIT = 8'hFF;
   // ========================================================================
   // Control states
   typedef enum logic [1:0] {
      ST_BOOT,
      ST_IDLE,
      ST_WARMUP,
      ST_MEASURE
   } fsa_state_t;
endpackage
`default_nettype wire

// file: logic/fsa_avg_if.sv
// Interface between the controller and the flow averager
`timescale 1ns/1ps
`default_nettype none
interface fsa_avg_if #(
   parameter int unsigned W = 16
);
   logic                sample_stb;
   logic signed [W-1:0] sample;
   logic                restart;
   logic signed [W-1:0] result;
   logic                smoothing;
   // Controller side
   modport ctrl (output sample_stb, sample, restart, input result, smoothing);
   // Averager side
   modport avg (input sample_stb, sample, restart, output result, smoothing);
endinterface
`default_nettype wire

// file: logic/fsa_crc8.sv
// Checksum over one 16-bit read word
`timescale 1ns/1ps
`default_nettype none
module fsa_crc8 #(
   parameter int unsigned         DW   = 16,
   parameter logic [7:0]          POLY = 8'h31,
   parameter logic [7:0]          INIT = 8'hFF
) (
   // Word in, checksum out
   input  wire logic [DW-1:0] data,
   output logic      [7:0]    crc
);
   // ========================================================================
   // Bitwise shift register, most significant bit first
   always_comb begin
      logic [7:0] c;
      c = INIT;
      for (int i = DW - 1; i >= 0; i--) begin
         if (c[7] ^ data[i]) begin
            c = {c[6:0], 1'b0} ^ POLY;
         end else begin
            c = {c[6:0], 1'b0};
         end
      end
      crc = c;
   end
endmodule // fsa_crc8
`default_nettype wire

// file: logic/fsa_averager.sv
// Flow averager: arithmetic mean, then exponential smoothing
`timescale 1ns/1ps
`default_nettype none
module fsa_averager #(
   parameter int unsigned W       = 16,
   parameter int unsigned SAMPLES = 200,
   parameter int unsigned DIV     = 80,
   parameter int unsigned FRAC    = 8
) (
   // Clock, reset, enable
   input  wire logic clk,
   input  wire logic srst,
   input  wire logic ce,
   // Samples in, result out
   fsa_avg_if.avg    av
);
   localparam int unsigned NW = $clog2(SAMPLES + 1);
   localparam int unsigned SW = W + NW + 1;
   localparam int unsigned EW = W + FRAC + 1;

   if (SAMPLES < 2 || DIV < 2) begin : g_bad_param
      $error("fsa_averager: window or divisor too small");
   end

   logic signed [SW-1:0] sum_reg;
   logic        [NW-1:0] cnt_reg;
   logic signed [EW-1:0] ema_reg;
   logic signed [W-1:0]  result_reg;
   logic                 smooth_reg;
   logic signed [SW-1:0] sum_next;
   logic        [NW-1:0] cnt_next;
   logic signed [SW-1:0] mean_next;
   logic signed [EW-1:0] x_fx;
   logic signed [EW-1:0] ema_next;
   logic signed [EW-1:0] seed_fx;

   // ========================================================================
   // Next-value arithmetic
   always_comb begin
      sum_next  = av.restart ? SW'(av.sample) : sum_reg + SW'(av.sample);
      cnt_next  = av.restart ? NW'(1) : cnt_reg + NW'(1);
      mean_next = sum_next / $signed({1'b0, cnt_next});
      x_fx      = EW'(av.sample) <<< FRAC;
      ema_next  = ema_reg + (x_fx - ema_reg) / $signed(EW'(DIV));
      seed_fx   = EW'(mean_next) <<< FRAC;
   end

   // Sum, count and smoothing state
   always_ff @(posedge clk) begin
      if (srst) begin
         sum_reg    <= '0;
         cnt_reg    <= '0;
         ema_reg    <= '0;
         smooth_reg <= 1'b0;
      end else if (ce) begin
         if (av.sample_stb && smooth_reg && !av.restart) begin
            ema_reg <= ema_next;
         end else if (av.sample_stb) begin
            sum_reg <= sum_next;
            cnt_reg <= cnt_next;
            if (cnt_next == NW'(SAMPLES)) begin
               smooth_reg <= 1'b1;
               ema_reg    <= seed_fx;
            end else begin
               smooth_reg <= 1'b0;
            end
         end else if (av.restart) begin
            sum_reg    <= '0;
            cnt_reg    <= '0;
            smooth_reg <= 1'b0;
         end
      end
   end

   // Reported value, refreshed on every sample
   always_ff @(posedge clk) begin
      if (srst) begin
         result_reg <= '0;
      end else if (ce && av.sample_stb) begin
         if (smooth_reg && !av.restart) begin
            result_reg <= W'(ema_next >>> FRAC);
         end else begin
            result_reg <= W'(mean_next);
         end
      end
   end

   assign av.result    = result_reg;
   assign av.smoothing = smooth_reg;
endmodule // fsa_averager
`default_nettype wire

// file: logic/fsa_top.sv
// Flow sensor output logic: sampling, averaging, flags and register port
//
// Local design decisions: strobed register access and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module fsa_top #(
   parameter int unsigned FLOW_PERIOD  = fsa_pkg::FLOW_PERIOD_CYC,
   parameter int unsigned TEMP_PERIOD  = fsa_pkg::TEMP_PERIOD_CYC,
   parameter int unsigned READY_DELAY  = fsa_pkg::READY_CYC,
   parameter int unsigned FIRST_DELAY  = fsa_pkg::FIRST_RESULT_CYC,
   parameter int unsigned SAMPLES      = fsa_pkg::SMOOTH_SAMPLES
) (
   // Clock, reset, enable
   input  wire logic                          clk,
   input  wire logic                          srst,
   input  wire logic                          ce,
   // Register port
   input  wire logic [fsa_pkg::ADDR_W-1:0]    addr,
   input  wire logic [fsa_pkg::WORD_W-1:0]    wdata,
   input  wire logic                          wr_stb,
   input  wire logic                          rd_stb,
   output logic [fsa_pkg::WORD_W+fsa_pkg::CRC_W-1:0] rdata,
   // Front-end measurements
   input  wire logic signed [fsa_pkg::WORD_W-1:0] flow_in,
   input  wire logic                          high_flow_in,
   input  wire logic                          air_in,
   input  wire logic signed [fsa_pkg::WORD_W-1:0] temp_in,
   // Front-end control and alert pin
   output logic                               heater_on,
   output logic                               calib_alcohol,
   output logic                               new_data_alert_n
);
   localparam int unsigned W  = fsa_pkg::WORD_W;
   localparam int unsigned CW = fsa_pkg::CNT_W;

   if (FLOW_PERIOD < 2 || TEMP_PERIOD < FLOW_PERIOD || READY_DELAY < 1 ||
       FIRST_DELAY < 1 || SAMPLES < 2) begin : g_bad_param
      $error("fsa_top: timing parameters out of range");
   end

   // ========================================================================
   // Address decode helper
   function automatic logic hit(input logic [fsa_pkg::ADDR_W-1:0] a,
                                input logic [fsa_pkg::ADDR_W-1:0] r);
      hit = (a == r);
   endfunction

   fsa_pkg::fsa_state_t state_reg;
   logic [CW-1:0]       wait_cnt_reg;
   logic [CW-1:0]       flow_cnt_reg;
   logic [CW-1:0]       temp_cnt_reg;
   logic                alcohol_reg;
   logic                heater_reg;
   logic                air_flag_reg;
   logic                high_flag_reg;
   logic                alert_n_reg;
   logic signed [W-1:0] temp_reg;
   logic [W+fsa_pkg::CRC_W-1:0] rdata_reg;
   logic [W-1:0]        rd_word;
   logic [7:0]          rd_crc;
   logic                flow_tick;
   logic                temp_tick;
   logic                measuring;
   logic                ready;
   logic                cmd_wr;
   logic                flow_rd;
   logic                flags_rd;
   logic [W-1:0]        flag_word;
   logic [W-1:0]        status_word;

   // Carrier between the controller and the averager
   fsa_avg_if #(.W(W)) av ();

   // ========================================================================
   // Access qualifiers
   assign ready     = (state_reg != fsa_pkg::ST_BOOT);
   assign measuring = (state_reg == fsa_pkg::ST_MEASURE);
   assign cmd_wr    = ce && wr_stb && ready && hit(addr, fsa_pkg::REG_CMD);
   assign flow_rd   = ce && rd_stb && ready && hit(addr, fsa_pkg::REG_FLOW);
   assign flags_rd  = ce && rd_stb && ready && hit(addr, fsa_pkg::REG_FLAGS);

   // ========================================================================
   // Control sequence: boot, idle, warm-up, measure
   always_ff @(posedge clk) begin
      if (srst) begin
         state_reg    <= fsa_pkg::ST_BOOT;
         wait_cnt_reg <= '0;
      end else if (ce) begin
         case (state_reg)
            fsa_pkg::ST_BOOT: begin
               if (wait_cnt_reg >= CW'(READY_DELAY - 1)) begin
                  state_reg    <= fsa_pkg::ST_IDLE;
                  wait_cnt_reg <= '0;
               end else begin
                  wait_cnt_reg <= wait_cnt_reg + CW'(1);
               end
            end
            fsa_pkg::ST_IDLE: begin
               wait_cnt_reg <= '0;
               if (cmd_wr && (wdata == fsa_pkg::CMD_START_WATER ||
                              wdata == fsa_pkg::CMD_START_ALCOHOL)) begin
                  state_reg <= fsa_pkg::ST_WARMUP;
               end
            end
            fsa_pkg::ST_WARMUP: begin
               if (wait_cnt_reg >= CW'(FIRST_DELAY - 1)) begin
                  state_reg    <= fsa_pkg::ST_MEASURE;
                  wait_cnt_reg <= '0;
               end else begin
                  wait_cnt_reg <= wait_cnt_reg + CW'(1);
               end
            end
            // Leaves only on stop or soft reset
            fsa_pkg::ST_MEASURE: begin
               wait_cnt_reg <= '0;
            end
            default: begin
               state_reg    <= fsa_pkg::ST_BOOT;
               wait_cnt_reg <= '0;
            end
         endcase
         // Stop and soft reset override any state once ready
         if (cmd_wr && wdata == fsa_pkg::CMD_STOP) begin
            state_reg    <= fsa_pkg::ST_IDLE;
            wait_cnt_reg <= '0;
         end
         if (cmd_wr && wdata == fsa_pkg::CMD_SOFT_RESET) begin
            state_reg    <= fsa_pkg::ST_BOOT;
            wait_cnt_reg <= '0;
         end
      end
   end

   // ========================================================================
   // Calibration select and heater
   always_ff @(posedge clk) begin
      if (srst) begin
         alcohol_reg <= 1'b0;
         heater_reg  <= 1'b0;
      end else if (ce) begin
         if (cmd_wr && state_reg == fsa_pkg::ST_IDLE &&
             wdata == fsa_pkg::CMD_START_WATER) begin
            alcohol_reg <= 1'b0;
            heater_reg  <= 1'b1;
         end else if (cmd_wr && state_reg == fsa_pkg::ST_IDLE &&
                      wdata == fsa_pkg::CMD_START_ALCOHOL) begin
            alcohol_reg <= 1'b1;
            heater_reg  <= 1'b1;
         end else if (cmd_wr && (wdata == fsa_pkg::CMD_STOP ||
                                 wdata == fsa_pkg::CMD_SOFT_RESET)) begin
            heater_reg <= 1'b0;
            if (wdata == fsa_pkg::CMD_SOFT_RESET) begin
               alcohol_reg <= 1'b0;
            end
         end
      end
   end

   // ========================================================================
   // Flow sample period, back to back while measuring
   always_ff @(posedge clk) begin
      if (srst) begin
         flow_cnt_reg <= '0;
      end else if (ce) begin
         if (!measuring || flow_cnt_reg >= CW'(FLOW_PERIOD - 1)) begin
            flow_cnt_reg <= '0;
         end else begin
            flow_cnt_reg <= flow_cnt_reg + CW'(1);
         end
      end
   end
   assign flow_tick = ce && measuring && (flow_cnt_reg == CW'(FLOW_PERIOD - 1));

   // Temperature sample period
   always_ff @(posedge clk) begin
      if (srst) begin
         temp_cnt_reg <= '0;
      end else if (ce) begin
         if (!measuring || temp_cnt_reg >= CW'(TEMP_PERIOD - 1)) begin
            temp_cnt_reg <= '0;
         end else begin
            temp_cnt_reg <= temp_cnt_reg + CW'(1);
         end
      end
   end
   assign temp_tick = ce && measuring && (temp_cnt_reg == CW'(TEMP_PERIOD - 1));

   // Latest temperature, no averaging
   always_ff @(posedge clk) begin
      if (srst) begin
         temp_reg <= '0;
      end else if (temp_tick) begin
         temp_reg <= temp_in;
      end
   end

   // ========================================================================
   // Averager hookup; flow readout restarts the window
   // A read in a tick cycle opens the new window with that sample
   assign av.sample_stb = flow_tick;
   assign av.sample     = flow_in;
   assign av.restart    = flow_rd;

   fsa_averager #(
      .W       (W),
      .SAMPLES (SAMPLES),
      .DIV     (fsa_pkg::ALPHA_DIV),
      .FRAC    (fsa_pkg::EMA_FRAC)
   ) u_avg (
      .clk  (clk),
      .srst (srst),
      .ce   (ce),
      .av   (av)
   );

   // ========================================================================
   // Sticky failure flags; a new event beats the read clear
   // Air is judged at the temperature rate, high flow at the flow rate
   always_ff @(posedge clk) begin
      if (srst) begin
         high_flag_reg <= 1'b0;
         air_flag_reg  <= 1'b0;
      end else if (ce) begin
         if (flow_tick && high_flow_in) begin
            high_flag_reg <= 1'b1;
         end else if (flags_rd) begin
            high_flag_reg <= 1'b0;
         end
         if (temp_tick && air_in) begin
            air_flag_reg <= 1'b1;
         end else if (flags_rd) begin
            air_flag_reg <= 1'b0;
         end
      end
   end

   // New-data alert: low after a sample, high after a flow read
   always_ff @(posedge clk) begin
      if (srst) begin
         alert_n_reg <= 1'b1;
      end else if (ce) begin
         if (flow_tick) begin
            alert_n_reg <= 1'b0;
         end else if (flow_rd) begin
            alert_n_reg <= 1'b1;
         end
      end
   end

   // ========================================================================
   // Read words
   always_comb begin
      flag_word = '0;
      flag_word[fsa_pkg::FLAG_AIR_BIT]    = air_flag_reg;
      flag_word[fsa_pkg::FLAG_HIGH_BIT]   = high_flag_reg;
      flag_word[fsa_pkg::FLAG_SMOOTH_BIT] = av.smoothing;
      status_word = '0;
      status_word[fsa_pkg::STAT_READY_BIT]   = ready;
      status_word[fsa_pkg::STAT_MEAS_BIT]    = measuring;
      status_word[fsa_pkg::STAT_ALCOHOL_BIT] = alcohol_reg;
      status_word[fsa_pkg::STAT_HEATER_BIT]  = heater_reg;
   end

   // Zero before ready keeps an early poll from seeing stale data
   // Word select; nothing answers before ready
   always_comb begin
      rd_word = '0;
      if (ready) begin
         case (addr)
            fsa_pkg::REG_FLOW:   rd_word = av.result;
            fsa_pkg::REG_TEMP:   rd_word = temp_reg;
            fsa_pkg::REG_FLAGS:  rd_word = flag_word;
            fsa_pkg::REG_STATUS: rd_word = status_word;
            default:             rd_word = '0;
         endcase
      end
   end

   fsa_crc8 #(
      .DW   (W),
      .POLY (fsa_pkg::CRC_POLY),
      .INIT (fsa_pkg::CRC_INIT)
   ) u_crc (
      .data (rd_word),
      .crc  (rd_crc)
   );

   // Read data with checksum, valid the cycle after the strobe
   always_ff @(posedge clk) begin
      if (srst) begin
         rdata_reg <= '0;
      end else if (ce && rd_stb) begin
         rdata_reg <= {rd_word, rd_crc};
      end
   end

   // ========================================================================
   // Outputs
   assign rdata            = rdata_reg;
   assign heater_on        = heater_reg;
   assign calib_alcohol    = alcohol_reg;
   assign new_data_alert_n = alert_n_reg;
endmodule // fsa_top
`default_nettype wire

// file: tb/fsa_monitor.sv
// Checker of the flow averager register port and front-end pins
`timescale 1ns/1ps
`default_nettype none
module fsa_monitor (
   // Clock and reset
   input wire logic        clk,
   input wire logic        srst,
   input wire logic        ce,
   // Register port
   input wire logic [2:0]  addr,
   input wire logic [15:0] wdata,
   input wire logic        wr_stb,
   input wire logic        rd_stb,
   input wire logic [23:0] rdata,
   // Pins
   input wire logic        heater_on,
   input wire logic        calib_alcohol,
   input wire logic        new_data_alert_n
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (srst);
   // ========================================================================
   // Read kinds
   sequence flags_rd_s;
      rd_stb && addr == fsa_pkg::REG_FLAGS;
   endsequence
   sequence odd_rd_s;
      rd_stb && (addr == fsa_pkg::REG_CMD || addr > fsa_pkg::REG_STATUS);
   endsequence
   // ========================================================================
   // Properties
   rst_state_a: assert property (disable iff (1'b0)
      srst && ce |=> !heater_on && new_data_alert_n && rdata == 24'h000000)
      else $error("outputs not at reset values");
   heater_cause_a: assert property ($rose(heater_on) |-> $past(wr_stb &&
      (wdata == fsa_pkg::CMD_START_WATER || wdata == fsa_pkg::CMD_START_ALCOHOL)))
      else $error("heater started without start command");
   calib_pick_a: assert property ($rose(heater_on) |->
      calib_alcohol == ($past(wdata) == fsa_pkg::CMD_START_ALCOHOL))
      else $error("wrong calibration chosen");
   heater_idle_a: assert property (!heater_on && !wr_stb |=> !heater_on)
      else $error("heater on without command");
   heater_hold_a: assert property (heater_on && !wr_stb |=> heater_on)
      else $error("measurement stopped without command");
   read_hold_a: assert property (!rd_stb |=> $stable(rdata))
      else $error("read data changed without read");
   flags_mask_a: assert property (flags_rd_s |=> (rdata[23:8] & 16'hFFDC) == 16'h0000)
      else $error("undefined flag bits set");
   unmapped_zero_a: assert property (odd_rd_s |=> rdata[23:8] == 16'h0000)
      else $error("unmapped read not zero");
   alert_fall_a: assert property ($fell(new_data_alert_n) |-> $past(heater_on))
      else $error("alert without measurement");
   alert_rise_a: assert property ($rose(new_data_alert_n) |->
      $past(rd_stb && addr == fsa_pkg::REG_FLOW))
      else $error("alert released without flow read");
endmodule // fsa_monitor

bind fsa_top fsa_monitor u_fsa_monitor (
   .clk(clk), .srst(srst), .ce(ce), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
   .rd_stb(rd_stb), .rdata(rdata), .heater_on(heater_on),
   .calib_alcohol(calib_alcohol), .new_data_alert_n(new_data_alert_n)
);
`default_nettype wire

// file: tb/fsa_host_model.sv
// Host model: register bus master issuing commands and reads
`timescale 1ns/1ps
`default_nettype none
module fsa_host_model (
   // Clock and read data
   input  wire logic        clk,
   input  wire logic [23:0] rdata,
   // Bus requests
   output logic      [2:0]  addr,
   output logic      [15:0] wdata,
   output logic             wr_stb,
   output logic             rd_stb
);
   // Idle bus at time zero
   initial begin
      addr = 3'h0;
      wdata = 16'h0000;
      wr_stb = 1'b0;
      rd_stb = 1'b0;
   end
   // One-cycle command write, data inverted after release
   task automatic wr(input logic [15:0] c);
      @(posedge clk);
      addr <= fsa_pkg::REG_CMD;
      wdata <= c;
      wr_stb <= 1'b1;
      @(posedge clk);
      wr_stb <= 1'b0;
      wdata <= ~c;
   endtask
   // One-cycle read, data taken in the following cycle
   task automatic rd(input logic [2:0] a, output logic [23:0] d);
      @(posedge clk);
      addr <= a;
      rd_stb <= 1'b1;
      @(posedge clk);
      rd_stb <= 1'b0;
      addr <= ~a;
      #1 d = rdata;
   endtask
endmodule // fsa_host_model
`default_nettype wire

// file: tb/tb.sv
// Self-checking bench of the flow sample averager
`timescale 1ns/1ps
`default_nettype none
module tb;
   localparam int FP = 20;
   localparam int TP = 480;
   localparam int RD = 10;
   logic               clk, srst, ce, high, air, wr_stb, rd_stb;
   logic               heater_on, calib_alcohol, new_data_alert_n;
   logic signed [15:0] flow, temp;
   logic        [15:0] wdata;
   logic        [2:0]  addr;
   logic        [23:0] rdata, d;
   int                 n_fail, n_compared, cyc;
   fsa_top #(.FLOW_PERIOD(FP), .TEMP_PERIOD(TP), .READY_DELAY(RD), .FIRST_DELAY(30),
      .SAMPLES(8)) u_fsa_top (.clk(clk), .srst(srst), .ce(ce), .addr(addr), .wdata(wdata),
      .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .flow_in(flow), .high_flow_in(high),
      .air_in(air), .temp_in(temp), .heater_on(heater_on), .calib_alcohol(calib_alcohol),
      .new_data_alert_n(new_data_alert_n));
   fsa_host_model u_fsa_host_model (.clk(clk), .rdata(rdata), .addr(addr), .wdata(wdata),
      .wr_stb(wr_stb), .rd_stb(rd_stb));
   // Reference checksum, MSB first
   function automatic logic [7:0] crc(input logic [15:0] w);
      logic [7:0] c;
      c = fsa_pkg::CRC_INIT;
      for (int i = 15; i >= 0; i--) begin
         c = {c[6:0], 1'b0} ^ ((c[7] ^ w[i]) ? fsa_pkg::CRC_POLY : 8'h00);
      end
      return c;
   endfunction
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Read a word and judge word and checksum
   task automatic rchk(input logic [2:0] a, input logic [15:0] exp);
      u_fsa_host_model.rd(a, d);
      chk(d[23:8], exp);
      chk({8'h00, d[7:0]}, {8'h00, crc(exp)});
   endtask
   task automatic t_boot();
      chk({15'h0, heater_on}, 16'h0000);
      rchk(fsa_pkg::REG_STATUS, 16'h0000);
      repeat (RD) @(posedge clk);
      rchk(fsa_pkg::REG_STATUS, 16'h0001);
      rchk(3'h7, 16'h0000);
      rchk(fsa_pkg::REG_CMD, 16'h0000);
   endtask
   task automatic t_start();
      u_fsa_host_model.wr(fsa_pkg::CMD_START_ALCOHOL);
      #1 chk({14'h0, heater_on, calib_alcohol}, 16'h0003);
      rchk(fsa_pkg::REG_STATUS, 16'h000D);
      u_fsa_host_model.wr(fsa_pkg::CMD_STOP);
      u_fsa_host_model.wr(fsa_pkg::CMD_START_WATER);
      #1 chk({14'h0, heater_on, calib_alcohol}, 16'h0002);
      repeat (30 + 2 * FP) @(posedge clk);
   endtask
   // Window restart, mean of unlike samples, then smoothing of a step
   task automatic t_avg();
      flow <= -16'sd40;
      repeat (3) @(posedge clk);
      u_fsa_host_model.rd(fsa_pkg::REG_FLOW, d);
      repeat (FP) @(posedge clk);
      flow <= -16'sd10;
      repeat (2 * FP) @(posedge clk);
      flow <= 16'sd200;
      rchk(fsa_pkg::REG_FLOW, 16'hFFEC);
      repeat (8 * FP) @(posedge clk);
      flow <= 16'sd1000;
      repeat (3 * FP) @(posedge clk);
      rchk(fsa_pkg::REG_FLAGS, 16'h0020);
      rchk(fsa_pkg::REG_FLOW, 16'h00E5);
      rchk(fsa_pkg::REG_FLAGS, 16'h0000);
   endtask
   // Sticky failure flags, temperature and alert
   task automatic t_flags();
      high <= 1'b1;
      repeat (2 * FP) @(posedge clk);
      high <= 1'b0;
      repeat (FP) @(posedge clk);
      rchk(fsa_pkg::REG_FLAGS, 16'h0002);
      rchk(fsa_pkg::REG_FLAGS, 16'h0000);
      air <= 1'b1;
      temp <= 16'sh0123;
      repeat (TP + FP) @(posedge clk);
      air <= 1'b0;
      #1 chk({15'h0, new_data_alert_n}, 16'h0000);
      u_fsa_host_model.rd(fsa_pkg::REG_FLOW, d);
      chk({15'h0, new_data_alert_n}, 16'h0001);
      rchk(fsa_pkg::REG_FLAGS, 16'h0001);
      rchk(fsa_pkg::REG_FLAGS, 16'h0000);
      rchk(fsa_pkg::REG_TEMP, 16'h0123);
   endtask
   task automatic t_soft();
      u_fsa_host_model.wr(fsa_pkg::CMD_SOFT_RESET);
      #1 chk({15'h0, heater_on}, 16'h0000);
      rchk(fsa_pkg::REG_STATUS, 16'h0000);
      repeat (RD) @(posedge clk);
      rchk(fsa_pkg::REG_STATUS, 16'h0001);
   endtask
   task automatic end_of_test();
      $display("compared %0d, failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // Clock
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   // Hang guard
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 4000) begin
         n_fail++;
         end_of_test();
      end
   end
   // Main sequence
   initial begin
      {srst, ce, high, air} = 4'b1100;
      flow = 16'sd100;
      temp = 16'sh0000;
      {n_fail, n_compared, cyc} = '0;
      repeat (4) @(posedge clk);
      srst <= 1'b0;
      t_boot();
      t_start();
      t_avg();
      t_flags();
      t_soft();
      end_of_test();
   end
endmodule // tb
`default_nettype wire
